/* File: wcc_host_model.sv */
`timescale 1ns/10ps
// Bus controller in front of the checker: it only sends frames, write or read request, and never reads data back
module wcc_host_model (
  output logic scl,
  output logic sda_oe,
  input wire logic sda
);
  // Half of the 48 ns serial clock period
  localparam time HALF = 24;
  // Bus idle: clock stands high and the data line is released
  initial begin
    scl = 1'b1;
    sda_oe = 1'b0;
  end
  // One bit; data only moves while the clock is low
  task automatic put_bit(input logic b, output logic seen);
    sda_oe = ~b;
    #HALF;
    scl = 1'b1;
    #HALF;
    seen = sda;
    scl = 1'b0;
  endtask
  // Whole bytes MSB first, then an optional partial byte, then stop
  task automatic frame(input logic [4:0][7:0] b, input int nb,
                       input int tail, output logic [4:0] ack);
    logic s;
    ack = '0;
    sda_oe = 1'b1;
    #HALF;
    scl = 1'b0;
    for (int i = 0; i < nb; i++) begin
      for (int j = 7; j >= 0; j--) begin
        put_bit(b[i][j], s);
      end
      // Release for the acknowledge slot; pull-up wins if nobody drives
      put_bit(1'b1, s);
      ack[i] = ~s;
    end
    // Trailing bits that never make a byte
    for (int j = 0; j < tail; j++) begin
      put_bit(b[nb][7-j], s);
    end
    sda_oe = 1'b1;
    #HALF;
    scl = 1'b1;
    #HALF;
    sda_oe = 1'b0;
    #HALF;
  endtask
endmodule

/* File: wcc_i2c_write_crc_checker.sv */
`timescale 1ns/10ps
// Notes on behaviour
// - Fuse 0 skips the check, 1 checks all except in the configuration bypass
// - Compare own check byte with host's at end
// - Mismatch discards the write entirely
// - Mismatch sets fault flag, unmasked drives interrupt
// - Check byte: poly 0x1D, preset 0xFF
// - Configuration pin high, no power-up: bypass check
// - Whole bytes only; seven bits get no acknowledge
// - Target only; address 0x08 to 0x0F by fuse
module wcc_i2c_write_crc_checker (
  input wire logic clk,
  input wire logic rst,
  input wire logic scl_clk,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic crc_fuse_en,
  input wire logic [2:0] addr_fuse,
  input wire logic config_mode_select_pin,
  input wire logic power_up_active,
  input wire logic int_mask,
  input wire logic crc_flag_clear,
  output logic crc_fault_flag,
  output logic interrupt_out_n,
  output logic wr_valid,
  output logic [7:0] wr_reg_addr,
  output logic [7:0] wr_data
);
  // Link side: bit toggle and bit value, stable for a whole SCL period
  logic bit_tog;
  logic bit_val;
  // Synchronisers into the core clock
  logic scl_meta, scl_sync, scl_prev;
  logic sda_meta, sda_sync, sda_prev;
  logic tog_meta, tog_sync, tog_prev;
  logic cfg_meta, cfg_sync;
  // Byte assembly
  logic [3:0] bit_cnt;
  logic [7:0] shift;
  // Frame tracking
  wcc_pkg::wcc_state_type state;
  logic [7:0] crc_acc;
  logic [7:0] crc_rx;
  logic [7:0] reg_hold;
  logic [7:0] data_hold;
  logic bit_pend; // Bit sampled, waiting for SCL to fall
  // Decoded events
  logic bit_evt, bit_take, scl_fall, start_det, stop_det, byte_done;
  logic [7:0] rx_byte;
  logic [6:0] dev_addr;
  logic check_en, crc_ok, commit, fault, ack_now;

  // Sample SDA on each rising SCL edge; toggle marks a new bit
  always_ff @(posedge scl_clk or posedge rst) begin
    if (rst) begin
      bit_tog <= 1'b0;
      bit_val <= 1'b0;
    end else begin
      bit_tog <= ~bit_tog;
      bit_val <= sda_in;
    end
  end

  // Two-stage synchronisers for pins and the link toggle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      scl_meta <= 1'b1;
      scl_sync <= 1'b1;
      sda_meta <= 1'b1;
      sda_sync <= 1'b1;
      tog_meta <= 1'b0;
      tog_sync <= 1'b0;
      cfg_meta <= 1'b0;
      cfg_sync <= 1'b0;
    end else begin
      scl_meta <= scl_clk;
      scl_sync <= scl_meta;
      sda_meta <= sda_in;
      sda_sync <= sda_meta;
      tog_meta <= bit_tog;
      tog_sync <= tog_meta;
      cfg_meta <= config_mode_select_pin;
      cfg_sync <= cfg_meta;
    end
  end

  // Previous synced levels for edge detection
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      scl_prev <= 1'b1;
      sda_prev <= 1'b1;
      tog_prev <= 1'b0;
    end else begin
      scl_prev <= scl_sync;
      sda_prev <= sda_sync;
      tog_prev <= tog_sync;
    end
  end

  // Event decode; bit_val stands until the next SCL rise, past the fall
  always_comb begin
    bit_evt = tog_sync ^ tog_prev;
    scl_fall = scl_prev & ~scl_sync;
    bit_take = scl_fall & bit_pend;
    start_det = scl_sync & scl_prev & sda_prev & ~sda_sync;
    stop_det = scl_sync & scl_prev & ~sda_prev & sda_sync;
    byte_done = bit_take && (bit_cnt == wcc_pkg::WCC_LAST_BIT);
    rx_byte = {shift[6:0], bit_val};
  end

  // Address: fixed in configuration mode, else base plus fuse field
  assign dev_addr = cfg_sync ? wcc_pkg::WCC_CFG_ADDR
                             : (wcc_pkg::WCC_BASE_ADDR | {4'h0, addr_fuse});

  // Check active only with the fuse set and not in programming mode
  assign check_en = crc_fuse_en & ~(cfg_sync & ~power_up_active);
  assign crc_ok = (crc_acc == crc_rx);

  // Outcome at stop: check byte needed only when checking
  always_comb begin
    commit = 1'b0;
    fault = 1'b0;
    if (stop_det) begin
      if (check_en) begin
        commit = (state == wcc_pkg::wcc_st_done) && crc_ok;
        fault = (state == wcc_pkg::wcc_st_crc) ||
                ((state == wcc_pkg::wcc_st_done) && !crc_ok);
      end else begin
        commit = (state == wcc_pkg::wcc_st_crc) ||
                 (state == wcc_pkg::wcc_st_done);
      end
    end
  end

  // Acknowledge decision for the byte just completed
  always_comb begin
    case (state)
      wcc_pkg::wcc_st_addr: ack_now = (rx_byte[7:1] == dev_addr) &&
                                      !rx_byte[0];
      wcc_pkg::wcc_st_reg: ack_now = 1'b1;
      wcc_pkg::wcc_st_data: ack_now = 1'b1;
      wcc_pkg::wcc_st_crc: ack_now = 1'b1;
      default: ack_now = 1'b0;
    endcase
  end

  // A bit counts only once SCL falls; the SCL rise ahead of a stop
  // or start is no bit, or seven bits plus stop would make a byte
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bit_pend <= 1'b0;
    end else if (start_det || stop_det) begin
      bit_pend <= 1'b0;
    end else if (bit_evt) begin
      bit_pend <= 1'b1;
    end else if (scl_fall) begin
      bit_pend <= 1'b0;
    end
  end

  // Bit counter and shifter; the ack slot bit is dropped
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bit_cnt <= wcc_pkg::WCC_CNT_RST;
      shift <= wcc_pkg::WCC_BYTE_RST;
    end else if (start_det || stop_det) begin
      bit_cnt <= wcc_pkg::WCC_CNT_RST; // Partial bytes vanish
    end else if (bit_take) begin
      if (bit_cnt == wcc_pkg::WCC_ACK_SLOT) begin
        bit_cnt <= wcc_pkg::WCC_CNT_RST;
      end else begin
        shift <= rx_byte;
        bit_cnt <= bit_cnt + 4'h1;
      end
    end
  end

  // Frame state machine, one step per whole byte
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= wcc_pkg::wcc_st_idle;
    end else if (start_det) begin
      state <= wcc_pkg::wcc_st_addr; // Repeated start drops the frame
    end else if (stop_det) begin
      state <= wcc_pkg::wcc_st_idle;
    end else if (byte_done) begin
      case (state)
        wcc_pkg::wcc_st_addr: begin
          state <= ack_now ? wcc_pkg::wcc_st_reg
                           : wcc_pkg::wcc_st_ignore;
        end
        wcc_pkg::wcc_st_reg: state <= wcc_pkg::wcc_st_data;
        wcc_pkg::wcc_st_data: state <= wcc_pkg::wcc_st_crc;
        wcc_pkg::wcc_st_crc: state <= wcc_pkg::wcc_st_done;
        wcc_pkg::wcc_st_done: state <= wcc_pkg::wcc_st_ignore;
        default: state <= state;
      endcase
    end
  end

  // Running check over address, register and data bytes
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      crc_acc <= wcc_pkg::WCC_CRC_INIT;
    end else if (start_det) begin
      crc_acc <= wcc_pkg::WCC_CRC_INIT;
    end else if (byte_done && (state == wcc_pkg::wcc_st_addr ||
                               state == wcc_pkg::wcc_st_reg ||
                               state == wcc_pkg::wcc_st_data)) begin
      crc_acc <= wcc_pkg::wcc_crc8(crc_acc, rx_byte);
    end
  end

  // Hold the command bytes until the stop decides
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_hold <= wcc_pkg::WCC_BYTE_RST;
      data_hold <= wcc_pkg::WCC_BYTE_RST;
      crc_rx <= wcc_pkg::WCC_BYTE_RST;
    end else if (byte_done) begin
      if (state == wcc_pkg::wcc_st_reg) begin
        reg_hold <= rx_byte;
      end
      if (state == wcc_pkg::wcc_st_data) begin
        data_hold <= rx_byte;
      end
      if (state == wcc_pkg::wcc_st_crc) begin
        crc_rx <= rx_byte;
      end
    end
  end

  // Acknowledge: pull SDA low from the eighth fall to the ninth
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sda_oe <= 1'b0;
    end else if (start_det || stop_det) begin
      sda_oe <= 1'b0;
    end else if (byte_done) begin
      sda_oe <= ack_now; // Seven bits never get here
    end else if (bit_take && bit_cnt == wcc_pkg::WCC_ACK_SLOT) begin
      sda_oe <= 1'b0; // Let go once the ninth clock falls
    end
  end
  assign sda_out = 1'b0;

  // Committed write toward the register file
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_valid <= 1'b0;
      wr_reg_addr <= wcc_pkg::WCC_BYTE_RST;
      wr_data <= wcc_pkg::WCC_BYTE_RST;
    end else begin
      wr_valid <= commit;
      if (commit) begin
        wr_reg_addr <= reg_hold;
        wr_data <= data_hold;
      end
    end
  end

  // Sticky fault flag; a new fault beats a clear in the same cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      crc_fault_flag <= wcc_pkg::WCC_FLAG_RST;
    end else if (fault) begin
      crc_fault_flag <= 1'b1;
    end else if (crc_flag_clear) begin
      crc_fault_flag <= 1'b0;
    end
  end

  // Interrupt pin, low while the flag is up and unmasked
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      interrupt_out_n <= wcc_pkg::WCC_INT_N_RST;
    end else begin
      interrupt_out_n <= ~(crc_fault_flag & ~int_mask);
    end
  end

  // Checks
  fuse_off_a: assert property (@(posedge clk) disable iff (rst)
    $rose(crc_fault_flag) |-> $past(crc_fuse_en))
    else $error("fault flagged with check fuse off");
  commit_ok_a: assert property (@(posedge clk) disable iff (rst)
    wr_valid |-> (!$past(check_en) || $past(crc_ok)))
    else $error("write committed despite bad check byte");
  compare_a: assert property (@(posedge clk) disable iff (rst)
    (stop_det && check_en && state == wcc_pkg::wcc_st_done && !crc_ok)
    |=> crc_fault_flag && !wr_valid)
    else $error("mismatch not reported at stop");
  intr_pin_a: assert property (@(posedge clk) disable iff (rst)
    (crc_fault_flag && !int_mask) |=> !interrupt_out_n)
    else $error("interrupt not driven for unmasked fault");
  crc_preset_a: assert property (@(posedge clk) disable iff (rst)
    start_det |=> crc_acc == 8'hff)
    else $error("check register not preset at start");
  crc_step_a: assert property (@(posedge clk) disable iff (rst)
    (byte_done && !start_det && state == wcc_pkg::wcc_st_reg)
    |=> crc_acc == wcc_pkg::wcc_crc8($past(crc_acc), $past(rx_byte)))
    else $error("register byte not folded into check");
  bypass_a: assert property (@(posedge clk) disable iff (rst)
    (cfg_sync && !power_up_active) |=> !$rose(crc_fault_flag))
    else $error("check active in programming mode");
  ack_slot_a: assert property (@(posedge clk) disable iff (rst)
    $rose(sda_oe) |-> bit_cnt == wcc_pkg::WCC_ACK_SLOT)
    else $error("acknowledge outside the ninth bit");
  partial_drop_a: assert property (@(posedge clk) disable iff (rst)
    stop_det |=> (bit_cnt == wcc_pkg::WCC_CNT_RST) && !bit_pend && !sda_oe)
    else $error("partial byte survived a stop");
  addr_miss_a: assert property (@(posedge clk) disable iff (rst)
    (byte_done && !start_det && !stop_det &&
     state == wcc_pkg::wcc_st_addr && rx_byte[7:1] != dev_addr)
    |=> state == wcc_pkg::wcc_st_ignore ##1 !sda_oe)
    else $error("foreign address accepted");
  link_bit_a: assert property (@(posedge scl_clk) disable iff (rst)
    1'b1 |=> bit_tog != $past(bit_tog))
    else $error("link toggle stalled");
endmodule

/* File: wcc_i2c_write_crc_checker_tb.sv */
`timescale 1ns/10ps
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin \
  n_mismatch++; $display("BAD %s exp %h got %h", nm, e, g); end end
module wcc_i2c_write_crc_checker_tb;
  logic clk, rst, scl, host_oe, sda, sda_out, sda_oe;
  logic fuse, cfg, pwr, mask, clr, flag, int_n, wr_valid;
  logic [2:0] afuse;
  logic [7:0] wr_reg_addr, wr_data, got_reg, got_data, crc;
  logic [6:0] addr7;
  logic [4:0] ack, exp_ack;
  logic [4:0][7:0] b;
  logic ok_addr, chk, commit, fault, bad, rw;
  logic [31:0] seed, r;
  int n_mismatch, compares, n_wr, wr_before, nb, tail;
  // Open-drain data line with pull-up, resolved from both drivers
  assign sda = (sda_oe ? sda_out : 1'b1) & ~host_oe;
  wcc_i2c_write_crc_checker i_dut (.clk(clk), .rst(rst), .scl_clk(scl),
    .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .crc_fuse_en(fuse),
    .addr_fuse(afuse), .config_mode_select_pin(cfg), .power_up_active(pwr),
    .int_mask(mask), .crc_flag_clear(clr), .crc_fault_flag(flag),
    .interrupt_out_n(int_n), .wr_valid(wr_valid),
    .wr_reg_addr(wr_reg_addr), .wr_data(wr_data));
  wcc_host_model i_host (.scl(scl), .sda_oe(host_oe), .sda(sda));
  // Core clock, 5 ns
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // Commit monitor; the pulse lasts one cycle, so catch it every edge
  always @(negedge clk) begin
    if (wr_valid === 1'b1) begin
      n_wr++;
      got_reg = wr_reg_addr;
      got_data = wr_data;
    end
  end
  // Repeatable pseudo-random source
  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  // Serial check byte, one message bit at a time, preset all ones
  function automatic logic [7:0] crc_of(input logic [23:0] m);
    logic [7:0] c;
    c = 8'hff;
    for (int i = 23; i >= 0; i--) begin
      c = {c[6:0], 1'b0} ^ ((c[7] ^ m[i]) ? 8'h1d : 8'h00);
    end
    return c;
  endfunction
  task automatic print_verdict();
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // Watchdog well beyond forty frames of about 2.5 us each
  initial begin
    #400000;
    n_mismatch++;
    print_verdict();
  end
  initial begin
    {rst, fuse, cfg, pwr, mask, clr} = 6'h20;
    afuse = 3'h0;
    n_mismatch = 0;
    compares = 0;
    n_wr = 0;
    seed = 32'd81614;
    repeat (3) @(posedge clk);
    @(negedge clk) rst = 1'b0;
    for (int i = 0; i < 40; i++) begin
      seed = xs(seed);
      r = seed;
      // First frames force a checked corrupt and a checked clean write
      if (i < 2) begin
        r[24:16] = {1'b0, 2'h3, 1'b1, 1'b1, 3'h0, ~i[0]};
        r[23:22] = 2'h1;
      end
      @(negedge clk);
      {fuse, cfg, pwr, mask, bad} = r[20:16];
      afuse = r[27:25];
      nb = r[21] ? 4 : 3;
      tail = r[24] ? 7 : 0;
      // Settle the synchronised configuration pin before the frame
      repeat (6) @(negedge clk);
      addr7 = cfg ? 7'h08 : {4'h1, afuse};
      ok_addr = (r[23:22] != 2'h0);
      // Some refused frames carry our address but ask for a read
      rw = ~ok_addr & r[29];
      if (!ok_addr && !rw) begin
        addr7 = addr7 ^ (r[28] ? 7'h10 : 7'h01);
      end
      crc = crc_of({addr7, rw, r[7:0], r[15:8]}) ^ {7'h0, bad};
      b = {r[31:24], crc, r[15:8], r[7:0], addr7, rw};
      wr_before = n_wr;
      i_host.frame(b, nb, tail, ack);
      repeat (20) @(negedge clk);
      chk = fuse & ~(cfg & ~pwr);
      commit = ok_addr & (chk ? (nb == 4 && !bad) : 1'b1);
      fault = ok_addr & chk & ~commit;
      exp_ack = ok_addr ? ((nb == 4) ? 5'h0f : 5'h07) : 5'h00;
      `CHK("ack", exp_ack, ack)
      `CHK("commit", commit, n_wr == wr_before + 1)
      `CHK("extra commit", 1'b1, n_wr <= wr_before + 1)
      if (commit) begin
        `CHK("reg addr", r[7:0], got_reg)
        `CHK("data", r[15:8], got_data)
      end
      `CHK("fault flag", fault, flag)
      `CHK("interrupt", ~(fault & ~mask), int_n)
      // Clear the sticky flag and see the interrupt let go
      @(negedge clk) clr = 1'b1;
      @(negedge clk) clr = 1'b0;
      repeat (3) @(negedge clk);
      `CHK("flag clear", 1'b0, flag)
      `CHK("int release", 1'b1, int_n)
    end
    print_verdict();
  end
endmodule

/* File: wcc_pkg.sv */
package wcc_pkg;
  // Check byte generator and preset
  localparam logic [7:0] WCC_CRC_POLY = 8'h1d;
  localparam logic [7:0] WCC_CRC_INIT = 8'hff;
  // Target address base, low three bits come from the fuse field
  localparam logic [6:0] WCC_BASE_ADDR = 7'h08;
  // Fixed target address while the configuration pin is high
  localparam logic [6:0] WCC_CFG_ADDR = 7'h08;
  // Bit counter: last data bit index and acknowledge slot index
  localparam logic [3:0] WCC_LAST_BIT = 4'h7;
  localparam logic [3:0] WCC_ACK_SLOT = 4'h8;
  // Values after reset
  localparam logic [3:0] WCC_CNT_RST = 4'h0;
  localparam logic [7:0] WCC_BYTE_RST = 8'h00;
  localparam logic WCC_FLAG_RST = 1'b0;
  localparam logic WCC_INT_N_RST = 1'b1;

  // Frame states, Gray coded along the write path
  typedef enum logic [2:0] {
    wcc_st_idle = 3'b000,
    wcc_st_addr = 3'b001,
    wcc_st_reg = 3'b011,
    wcc_st_data = 3'b010,
    wcc_st_crc = 3'b110,
    wcc_st_done = 3'b111,
    wcc_st_ignore = 3'b101
  } wcc_state_type;

  // One byte through the check register, most significant bit first
  function automatic logic [7:0] wcc_crc8(input logic [7:0] crc,
                                          input logic [7:0] data);
    logic [7:0] c;
    c = crc ^ data;
    for (int i = 0; i < 8; i++) begin
      c = c[7] ? ((c << 1) ^ WCC_CRC_POLY) : (c << 1);
    end
    return c;
  endfunction
endpackage
